// ==== cfc_pkg.sv ====
// package: shared constants and helpers for the CAN FIFO control block
`default_nettype none
package cfc_pkg;
  // ==================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PTR_OFS = 8'h04;
  localparam logic [7:0] IRQ_ST_OFS = 8'h08;
  localparam logic [7:0] IRQ_MSK_OFS = 8'h0C;
  // ==================================================
  // control register fields
  localparam int DEPTH_LSB = 16;
  localparam int DEPTH_W = 5;
  localparam int RESET_BIT = 14;
  localparam int ADV_BIT = 13;
  localparam int PONLY_BIT = 12;
  localparam int DIR_BIT = 7;
  localparam int ABT_BIT = 6;
  localparam int LARB_BIT = 5;
  localparam int TERR_BIT = 4;
  localparam int TX_REQUEST_BIT = 3;
  localparam int RTR_BIT = 2;
  localparam int PRI_LSB = 0;
  localparam logic [31:0] CTRL_RSV_MASK = 32'hFFE0_8F00;
  localparam logic [2:0] CONFIG_MODE = 3'h4;
  // ==================================================
  // pointer status fields
  localparam int TAIL_LSB = 8;
  localparam int CNT_LSB = 16;
  // ==================================================
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_ABT = 0;
  localparam int IRQ_LARB = 1;
  localparam int IRQ_TERR = 2;
  localparam int IRQ_RST = 3;
  // ==================================================
  // reset values and bus answers
  localparam logic [4:0] DEPTH_RST = 5'h00;
  localparam logic [1:0] PRI_RST = 2'h0;
  localparam logic [3:0] IRQ_RST_VAL = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_CLEAR = 2'b01,
    RST_DONE = 2'b10
  } cfc_rst_type;

  function automatic logic [4:0] cfc_wrap_inc(input logic [4:0] p,
                                              input logic [4:0] last);
    return (p == last) ? 5'h00 : 5'(p + 5'h01);
  endfunction
endpackage
`default_nettype wire

// ==== cfc_ptr_if.sv ====
// interface: pointer control between the register side and pointer logic
`timescale 1ns/1ns
`default_nettype none
interface cfc_ptr_if;
  logic clr;
  logic adv_head;
  logic adv_tail;
  logic [4:0] depth;
  logic [4:0] head;
  logic [4:0] tail;
  logic [5:0] count;
  modport ctl (output clr, adv_head, adv_tail, depth,
               input head, tail, count);
  modport ptr (input clr, adv_head, adv_tail, depth,
               output head, tail, count);
endinterface
`default_nettype wire

// ==== cfc_ptr.sv ====
// module: head, tail and occupancy of one message FIFO
`timescale 1ns/1ns
`default_nettype none
module cfc_ptr (
  input wire logic aclk,
  input wire logic aresetn,
  cfc_ptr_if.ptr pif
);
  import cfc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [4:0] head_q;
  logic [4:0] tail_q;
  logic [5:0] count_q;
  logic full;
  logic push;
  logic pop;

  // ==================================================
  // occupancy
  assign full = (count_q == 6'({1'b0, pif.depth} + 6'h01));
  // overflowing or underflowing advances are dropped, not wrapped
  assign push = pif.adv_head && !full;
  assign pop = pif.adv_tail && (count_q != 6'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn || pif.clr) begin
      head_q <= 5'h00;
    end else if (push) begin
      head_q <= cfc_wrap_inc(head_q, pif.depth);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pif.clr) begin
      tail_q <= 5'h00;
    end else if (pop) begin
      tail_q <= cfc_wrap_inc(tail_q, pif.depth);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pif.clr) begin
      count_q <= 6'h00;
    end else begin
      count_q <= 6'(count_q + {5'h00, push} - {5'h00, pop});
    end
  end

  assign pif.head = head_q;
  assign pif.tail = tail_q;
  assign pif.count = count_q;

  // ==================================================
  // checks
  depth_bound_a: assert property (
    count_q <= 6'({1'b0, pif.depth} + 6'h01))
    else $error("occupancy above configured depth");
  head_wrap_a: assert property (
    (push && !pif.clr && head_q == pif.depth) |=> head_q == 5'h00)
    else $error("head did not wrap at depth");
  ptr_clear_a: assert property (
    pif.clr |=> (head_q == 5'h00 && tail_q == 5'h00 && count_q == 6'h00))
    else $error("fifo reset left pointers set");
endmodule // cfc_ptr
`default_nettype wire

// ==== cfc_irq.sv ====
// module: sticky interrupt status, mask and level output
`timescale 1ns/1ns
`default_nettype none
module cfc_irq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cfc_pkg::IRQ_W-1:0] ev,
  input wire logic st_wr,
  input wire logic msk_wr,
  input wire logic [cfc_pkg::IRQ_W-1:0] wd,
  output logic [cfc_pkg::IRQ_W-1:0] st_q,
  output logic [cfc_pkg::IRQ_W-1:0] msk_q,
  output logic irq_q
);
  import cfc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // set beats write-one-to-clear so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= IRQ_RST_VAL;
    end else begin
      st_q <= (st_q & ~(st_wr ? wd : IRQ_RST_VAL)) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msk_q <= IRQ_RST_VAL;
    end else if (msk_wr) begin
      msk_q <= wd;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(st_q & msk_q);
    end
  end

  sticky_set_a: assert property (
    (|ev) |=> ((st_q & $past(ev)) == $past(ev)))
    else $error("event lost against a clear");
  irq_follow_a: assert property (
    (|(st_q & msk_q)) |=> irq_q)
    else $error("unmasked status without interrupt");
endmodule // cfc_irq
`default_nettype wire

// ==== cfc_fifo_ctl.sv ====
// module: CAN message FIFO control register and status, AXI4-Lite slave
//
// Summary of operation
// - depth field five bits, depth is value+1
// - reset bit resets fifo, hardware clears it
// - tx fifo: advance moves head one message
// - rx fifo: advance moves tail one message
// - rx payload-only stores data, else whole message
// - tx fifo ignores the payload-only control
// - direction one is transmit, zero receive
// - depth, payload-only change only in configuration mode
// - aborted flag: set/clear on finish, fifo reset
// - arbitration, error flags clear on control read
// - unimplemented control bits read as zero
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module cfc_fifo_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] op_mode,
  input wire logic eng_push,
  input wire logic eng_pop,
  input wire logic tx_done,
  input wire logic tx_abort,
  input wire logic arb_lost,
  input wire logic tx_error,
  output logic [cfc_pkg::DEPTH_W-1:0] fifo_depth,
  output logic direction_select,
  output logic payload_store,
  output logic tx_request,
  output logic remote_frame_auto_reply,
  output logic [1:0] tx_priority,
  output logic [4:0] fifo_head,
  output logic [4:0] fifo_tail,
  output logic [5:0] fifo_count,
  output logic irq
);
  import cfc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic rsel_ctrl_q;
  logic [4:0] depth_q;
  logic ponly_q;
  logic dir_q;
  logic abt_q;
  logic larb_q;
  logic terr_q;
  logic tx_request_q;
  logic rtr_q;
  logic [1:0] pri_q;
  logic adv_q;
  logic store_q;
  cfc_rst_type rst_st_q;
  logic wr_en;
  logic wr_ctrl;
  logic wr_st;
  logic wr_msk;
  logic wr_hit;
  logic rd_take;
  logic rd_ctrl;
  logic rd_hit;
  logic cfg_ok;
  logic [31:0] ctrl_rd;
  logic [31:0] rd_word;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] irq_st;
  logic [IRQ_W-1:0] irq_msk;
  logic irq_q;

  cfc_ptr_if pif ();

  // ==================================================
  // AXI4-Lite write channels
  // address and data are latched in either order; the write acts once both
  // are held and the previous response is gone
  assign wr_en = !awready_q && !wready_q && !bvalid_q;
  assign wr_ctrl = wr_en && (awaddr_q == CTRL_OFS);
  assign wr_st = wr_en && (awaddr_q == IRQ_ST_OFS);
  assign wr_msk = wr_en && (awaddr_q == IRQ_MSK_OFS);
  assign wr_hit = wr_ctrl || wr_st || wr_msk || (awaddr_q == PTR_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      awaddr_q <= 8'h00;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      awaddr_q <= awaddr;
    end else if (bvalid_q && bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (bvalid_q && bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==================================================
  // AXI4-Lite read channels
  assign rd_take = arvalid && arready_q;
  assign rd_ctrl = rd_take && (araddr == CTRL_OFS);
  assign rd_hit = (araddr == CTRL_OFS) || (araddr == PTR_OFS) ||
                  (araddr == IRQ_ST_OFS) || (araddr == IRQ_MSK_OFS);

  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[DEPTH_LSB +: DEPTH_W] = depth_q;
    ctrl_rd[RESET_BIT] = (rst_st_q != RST_IDLE);
    ctrl_rd[ADV_BIT] = adv_q;
    ctrl_rd[PONLY_BIT] = ponly_q;
    ctrl_rd[DIR_BIT] = dir_q;
    ctrl_rd[ABT_BIT] = abt_q;
    ctrl_rd[LARB_BIT] = larb_q;
    ctrl_rd[TERR_BIT] = terr_q;
    ctrl_rd[TX_REQUEST_BIT] = tx_request_q;
    ctrl_rd[RTR_BIT] = rtr_q;
    ctrl_rd[PRI_LSB +: 2] = pri_q;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (araddr)
      CTRL_OFS: rd_word = ctrl_rd;
      PTR_OFS: begin
        rd_word[4:0] = pif.head;
        rd_word[TAIL_LSB +: 5] = pif.tail;
        rd_word[CNT_LSB +: 6] = pif.count;
      end
      IRQ_ST_OFS: rd_word[IRQ_W-1:0] = irq_st;
      IRQ_MSK_OFS: rd_word[IRQ_W-1:0] = irq_msk;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      rsel_ctrl_q <= 1'b0;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rsel_ctrl_q <= (araddr == CTRL_OFS);
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ==================================================
  // configuration fields
  assign cfg_ok = (op_mode == CONFIG_MODE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth_q <= DEPTH_RST;
    end else if (wr_ctrl && cfg_ok && wstrb_q[2]) begin
      depth_q <= wdata_q[DEPTH_LSB +: DEPTH_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ponly_q <= 1'b0;
    end else if (wr_ctrl && cfg_ok && wstrb_q[1]) begin
      ponly_q <= wdata_q[PONLY_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= 1'b0;
      rtr_q <= 1'b0;
      pri_q <= PRI_RST;
    end else if (wr_ctrl && wstrb_q[0]) begin
      dir_q <= wdata_q[DIR_BIT];
      rtr_q <= wdata_q[RTR_BIT];
      pri_q <= wdata_q[PRI_LSB +: 2];
    end
  end

  // a new request from software wins over the engine finishing the old one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_request_q <= 1'b0;
    end else if (wr_ctrl && wstrb_q[0]) begin
      tx_request_q <= wdata_q[TX_REQUEST_BIT];
    end else if (tx_done || tx_abort) begin
      tx_request_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_q <= 1'b0;
    end else begin
      store_q <= !dir_q && ponly_q;
    end
  end

  // ==================================================
  // fifo reset sequence
  // set, reset, then self-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_st_q <= RST_IDLE;
    end else begin
      case (rst_st_q)
        RST_IDLE: begin
          if (wr_ctrl && wstrb_q[1] && wdata_q[RESET_BIT]) begin
            rst_st_q <= RST_CLEAR;
          end
        end
        RST_CLEAR: rst_st_q <= RST_DONE;
        RST_DONE: rst_st_q <= RST_IDLE;
        default: rst_st_q <= RST_IDLE;
      endcase
    end
  end

  // ==================================================
  // pointer advance
  // self-clearing: reads back as one only in the cycle it acts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_q <= 1'b0;
    end else begin
      adv_q <= wr_ctrl && wstrb_q[1] && wdata_q[ADV_BIT];
    end
  end

  assign pif.clr = (rst_st_q == RST_CLEAR);
  assign pif.depth = depth_q;
  assign pif.adv_head = dir_q ? adv_q : eng_push;
  assign pif.adv_tail = dir_q ? eng_pop : adv_q;

  cfc_ptr u_ptr (
    .aclk(aclk),
    .aresetn(aresetn),
    .pif(pif)
  );

  // ==================================================
  // transmit status flags
  // abort status
  always_ff @(posedge aclk) begin
    if (!aresetn || pif.clr) begin
      abt_q <= 1'b0;
    end else if (tx_abort) begin
      abt_q <= 1'b1;
    end else if (tx_done) begin
      abt_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pif.clr) begin
      larb_q <= 1'b0;
      terr_q <= 1'b0;
    end else begin
      larb_q <= arb_lost || (larb_q && !rd_ctrl);
      terr_q <= tx_error || (terr_q && !rd_ctrl);
    end
  end

  // ==================================================
  // interrupts
  assign ev[IRQ_ABT] = tx_abort;
  assign ev[IRQ_LARB] = arb_lost;
  assign ev[IRQ_TERR] = tx_error;
  assign ev[IRQ_RST] = (rst_st_q == RST_DONE);

  cfc_irq u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev),
    .st_wr(wr_st && wstrb_q[0]),
    .msk_wr(wr_msk && wstrb_q[0]),
    .wd(wdata_q[IRQ_W-1:0]),
    .st_q(irq_st),
    .msk_q(irq_msk),
    .irq_q(irq_q)
  );

  // ==================================================
  // outputs
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign fifo_depth = depth_q;
  assign direction_select = dir_q;
  assign payload_store = store_q;
  assign tx_request = tx_request_q;
  assign remote_frame_auto_reply = rtr_q;
  assign tx_priority = pri_q;
  assign fifo_head = pif.head;
  assign fifo_tail = pif.tail;
  assign fifo_count = pif.count;
  assign irq = irq_q;

  // ==================================================
  // checks
  reset_selfclr_a: assert property (
    (rst_st_q == RST_CLEAR) |=> (rst_st_q == RST_DONE) ##1
    (rst_st_q == RST_IDLE))
    else $error("fifo reset bit did not self-clear");
  head_step_a: assert property (
    (dir_q && adv_q && pif.count != 6'({1'b0, depth_q} + 6'h01)
     && !pif.clr) |=> pif.head == cfc_wrap_inc($past(pif.head),
                                                $past(depth_q)))
    else $error("transmit advance did not move head");
  tail_step_a: assert property (
    (!dir_q && adv_q && pif.count != 6'h00 && !pif.clr)
    |=> pif.tail == cfc_wrap_inc($past(pif.tail), $past(depth_q)))
    else $error("receive advance did not move tail");
  payload_mode_a: assert property (
    (!dir_q && ponly_q) |=> store_q)
    else $error("payload-only store not applied");
  tx_ignore_a: assert property (
    dir_q |=> !store_q)
    else $error("payload-only active on transmit fifo");
  dir_write_a: assert property (
    (wr_ctrl && wstrb_q[0]) |=> dir_q == $past(wdata_q[DIR_BIT]))
    else $error("direction bit not written");
  cfg_lock_a: assert property (
    (wr_ctrl && !cfg_ok) |=> ($stable(depth_q) && $stable(ponly_q)))
    else $error("depth changed outside configuration mode");
  abort_flag_a: assert property (
    (tx_abort && !pif.clr) |=> abt_q)
    else $error("abort did not set aborted flag");
  read_clear_a: assert property (
    (rd_ctrl && !arb_lost && !tx_error) |=> (!larb_q && !terr_q))
    else $error("flags survived a control read");
  rsv_zero_a: assert property (
    (rvalid_q && rsel_ctrl_q) |-> ((rdata_q & CTRL_RSV_MASK) == 32'h0000_0000))
    else $error("reserved control bits read non-zero");
endmodule // cfc_fifo_ctl
`default_nettype wire

// ==== cfc_engine_model.sv ====
// partner model: CAN message engine pulsing its event lines
`timescale 1ns/1ns
`default_nettype none
module cfc_engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [5:0] ev_req,
  input wire logic [3:0] lag,
  output logic [5:0] ev_q,
  output logic busy
);
  logic [5:0] pend_q;
  logic [3:0] cnt_q;
  // ==================================================
  // event pulses
  // a lag lets the engine answer promptly or slowly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_q <= '0;
      pend_q <= '0;
      cnt_q <= '0;
    end else begin
      ev_q <= '0;
      if (start) begin
        pend_q <= ev_req;
        cnt_q <= lag;
      end else if (pend_q != '0) begin
        if (cnt_q == '0) begin
          ev_q <= pend_q;
          pend_q <= '0;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end
  assign busy = start | (|pend_q) | (|ev_q);
endmodule // cfc_engine_model
`default_nettype wire

// ==== can_message_fifo_control_tb.sv ====
// testbench: FIFO control block against a behavioural model
`timescale 1ns/1ns
`default_nettype none
module can_message_fifo_control_tb;
  import cfc_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, start, busy, irq, irq_a;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, lag;
  logic [1:0] bresp, rresp, tx_priority, rs;
  logic [2:0] op_mode, om;
  logic [5:0] ev, ev_req, fifo_count;
  logic [4:0] fifo_depth, fifo_head, fifo_tail;
  logic direction_select, payload_store, tx_request, remote_frame_auto_reply;
  int fails, check_count, cyc, seed;
  int dep, pol, dir, abt, larb, terr, txr, rtr, pri, head, tail, cnt;

  cfc_fifo_ctl uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .op_mode,
    .eng_push(ev[0]), .eng_pop(ev[1]), .tx_done(ev[2]), .tx_abort(ev[3]),
    .arb_lost(ev[4]), .tx_error(ev[5]), .fifo_depth, .direction_select,
    .payload_store, .tx_request, .remote_frame_auto_reply, .tx_priority,
    .fifo_head, .fifo_tail, .fifo_count, .irq);
  cfc_engine_model eng_m (.aclk, .aresetn, .start, .ev_req, .lag,
    .ev_q(ev), .busy);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ==================================================
  // model and checks
  function automatic logic [31:0] ctl_m();
    return 32'(dep << DEPTH_LSB | pol << PONLY_BIT | dir << DIR_BIT |
               abt << ABT_BIT | larb << LARB_BIT | terr << TERR_BIT |
               txr << TX_REQUEST_BIT | rtr << RTR_BIT | pri << PRI_LSB);
  endfunction
  function automatic logic [31:0] ptr_m();
    return 32'(head | tail << TAIL_LSB | cnt << CNT_LSB);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // ==================================================
  // bus and engine drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
    bready <= 1'b0;
    // advance and reset act two edges after the write lands
    repeat (3) @(posedge aclk);
  endtask
  task automatic rd_t(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    rd_t(a, rd, rs);
    chk(nm, e, rd);
  endtask
  task automatic wctl(input int extra);
    wr(CTRL_OFS, ctl_m() | 32'(extra), RESP_OKAY);
  endtask
  task automatic eng(input int b);
    start <= 1'b1;
    ev_req <= 6'(1 << b);
    lag <= 4'($random(seed) & 3);
    @(posedge aclk);
    start <= 1'b0;
    while (busy) @(posedge aclk);
    @(posedge aclk);
  endtask

  // ==================================================
  // main sequence
  initial begin
    seed = 70;
    {awvalid, wvalid, bready, arvalid, rready, start} = '0;
    {awaddr, araddr, wdata, ev_req, lag} = '0;
    wstrb = 4'hF;
    op_mode = 3'h0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("ctrl", CTRL_OFS, 32'h0000_0000);
    rchk("ptr", PTR_OFS, 32'h0000_0000);
    op_mode <= CONFIG_MODE;
    dep = 31;
    pol = 1;
    wr(CTRL_OFS, ctl_m() | CTRL_RSV_MASK, RESP_OKAY);
    rchk("ctrl", CTRL_OFS, ctl_m());
    chk("depth", 32'd31, fifo_depth);
    chk("pstore", 32'd1, payload_store);
    dep = 3;
    wctl(0);
    om = 3'($random(seed));
    if (om == CONFIG_MODE) om = 3'h0;
    op_mode <= om;
    wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    rchk("ctrl", CTRL_OFS, ctl_m());
    chk("depth", 32'd3, fifo_depth);
    for (int i = 0; i < 4; i++) begin
      eng(0);
      head = (head == dep) ? 0 : head + 1;
      cnt++;
      chk("head", head, fifo_head);
    end
    eng(1);
    rchk("ptr", PTR_OFS, ptr_m());
    wctl(1 << ADV_BIT);
    tail = 1;
    cnt--;
    rchk("ptr", PTR_OFS, ptr_m());
    chk("tail", tail, fifo_tail);
    chk("count", cnt, fifo_count);
    wctl(1 << RESET_BIT);
    for (int n = 0; n < 20; n++) begin
      rd_t(CTRL_OFS, rd, rs);
      if (rd[RESET_BIT] === 1'b0) break;
    end
    chk("reset bit", 32'd0, rd[RESET_BIT]);
    head = 0;
    tail = 0;
    cnt = 0;
    rchk("ptr", PTR_OFS, ptr_m());
    dir = 1;
    txr = 1;
    rtr = 1;
    pri = $random(seed) & 3;
    wctl(0);
    chk("pstore", 32'd0, payload_store);
    chk("dir", 32'd1, direction_select);
    chk("tx_request", 32'd1, tx_request);
    chk("rtr", 32'd1, remote_frame_auto_reply);
    chk("prio", pri, tx_priority);
    wctl(1 << ADV_BIT);
    head = 1;
    cnt = 1;
    chk("head", head, fifo_head);
    eng(1);
    tail = 1;
    cnt = 0;
    rchk("ptr", PTR_OFS, ptr_m());
    eng(3);
    abt = 1;
    txr = 0;
    rchk("ctrl", CTRL_OFS, ctl_m());
    chk("tx_request", 32'd0, tx_request);
    eng(2);
    abt = 0;
    rchk("ctrl", CTRL_OFS, ctl_m());
    eng(4);
    eng(5);
    larb = 1;
    terr = 1;
    rchk("ctrl", CTRL_OFS, ctl_m());
    larb = 0;
    terr = 0;
    rchk("ctrl", CTRL_OFS, ctl_m());
    // lane 0 gated off: direction, request, reply and priority must hold
    wstrb <= 4'hE;
    wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hF;
    rchk("ctrl", CTRL_OFS, ctl_m());
    // mask polarity is left open, so only the change of irq is judged
    rchk("irq st", IRQ_ST_OFS, 32'h0000_000F);
    wr(IRQ_MSK_OFS, 32'h0000_0000, RESP_OKAY);
    irq_a = irq;
    wr(IRQ_MSK_OFS, 32'h0000_000F, RESP_OKAY);
    chk("irq mask", 32'd1, irq ^ irq_a);
    wr(IRQ_ST_OFS, 32'h0000_000F, RESP_OKAY);
    rchk("irq st", IRQ_ST_OFS, 32'h0000_0000);
    chk("irq", 32'd0, irq);
    wr(IRQ_MSK_OFS, 32'h0000_0000, RESP_OKAY);
    chk("irq", 32'd0, irq);
    wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
    rd_t(8'h10, rd, rs);
    chk("rresp", RESP_SLVERR, rs);
    chk("rdata", 32'h0000_0000, rd);
    wr(PTR_OFS, 32'hFFFF_FFFF, RESP_OKAY);
    rchk("ptr", PTR_OFS, ptr_m());
    results();
  end
endmodule // can_message_fifo_control_tb
`default_nettype wire
